// file: rtl/cod_clock_control.sv
// top of the clock output control block: register file and channels
// assumes a classic wishbone master on clk_i and asynchronous pins
`timescale 1ns/10ps
`default_nettype none

module cod_clock_control (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire cod_pkg::cod_wb_req_s wb_req_i,
  output cod_pkg::cod_wb_rsp_s wb_rsp_o,
  input wire logic first_clock_input_i,
  input wire logic second_clock_input_i,
  input wire logic output_gate_pin_i,
  input wire logic sync_n_i,
  output logic [cod_pkg::NUM_CHAN-1:0] clock_output_n_o,
  output logic [cod_pkg::NUM_CHAN-1:0] channel_active_o,
  output logic [cod_pkg::NUM_CHAN-1:0][11:0] path_delay_ps_o,
  output logic boost_enable_o,
  output logic device_shutdown_o,
  output logic input_source_select_o
);

  import cod_pkg::*;

  // bus handshake states
  typedef enum logic [1:0] {
    WB_IDLE = 2'b01,
    WB_ACK = 2'b10
  } cod_wb_state_e;

  // byte-lane merge of a write into a stored word
  function automatic logic [31:0] merge_sel(
    input logic [31:0] old_w,
    input logic [31:0] new_w,
    input logic [3:0] sel,
    input logic [31:0] mask
  );
    logic [31:0] res;
    res = old_w;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[b*8 +: 8] = new_w[b*8 +: 8];
      end
    end
    return res & mask;
  endfunction

  // true when the divider stage sits in the path
  function automatic logic mode_has_div(input cod_mode_e m);
    return (m == MODE_DIV) || (m == MODE_DIVDLY);
  endfunction

  // true when the delay stage sits in the path
  function automatic logic mode_has_dly(input cod_mode_e m);
    return (m == MODE_DLY) || (m == MODE_DIVDLY);
  endfunction

  // fixed latency of the selected path relative to bypass
  function automatic logic [11:0] mode_latency(input cod_mode_e m);
    logic [11:0] lat;
    lat = 12'h000;
    unique case (m)
      MODE_BYPASS: lat = 12'h000;
      MODE_DIV: lat = LAT_DIV_PS;
      MODE_DLY: lat = LAT_DLY_PS;
      MODE_DIVDLY: lat = LAT_DIVDLY_PS;
    endcase
    return lat;
  endfunction

  // stored state
  cod_chan_s chan_reg [NUM_CHAN];
  logic [31:0] global_reg;
  logic [31:0] boost_reg;
  cod_wb_state_e wb_state_reg;
  cod_wb_state_e wb_state_next;
  logic ack_reg;
  logic [31:0] rdat_reg;

  // pin synchroniser stages; only the second stage is read by logic
  logic [3:0] pin_meta_reg;
  logic [3:0] pin_sync_reg;
  logic sel_clk_prev_reg;
  logic bypass_clk_reg;
  logic [NUM_CHAN-1:0] out_reg;
  logic [NUM_CHAN-1:0] active_reg;
  logic [NUM_CHAN-1:0][11:0] dly_ps_reg;
  logic [NUM_CHAN-1:0] div_clk;

  // decoded bus request
  logic [3:0] wb_idx;
  logic wb_take;
  logic wb_write;
  logic wb_hit;
  logic soft_reset;
  logic [31:0] rd_word;

  // decoded global control
  logic glob_select;
  logic glob_enable;
  logic glob_shutdown;
  logic gate_sync;
  logic sync_held;
  logic sel_clk;
  logic src_tick;
  logic outputs_allowed;

  // bus decode
  assign wb_idx = wb_req_i.adr[5:2];
  assign wb_take = wb_req_i.cyc & wb_req_i.stb & (wb_state_reg == WB_IDLE);
  assign wb_write = wb_take & wb_req_i.we;
  assign wb_hit = (wb_idx < 4'(NUM_CHAN)) || (wb_idx == IDX_BOOST) ||
                  (wb_idx == IDX_GLOBAL) || (wb_idx == IDX_STATUS);

  // a write of one to bit 31 of word 0 restores every default
  assign soft_reset = wb_write && (wb_idx == IDX_CHAN0) &&
                      wb_req_i.sel[3] && wb_req_i.dat[SOFT_RST_BIT];

  // global control fields
  assign glob_select = global_reg[SEL_BIT];
  assign glob_enable = global_reg[GLOB_EN_BIT];
  assign glob_shutdown = global_reg[PD_BIT];

  // synchronised pins: 0 first input, 1 second input, 2 gate, 3 sync
  assign gate_sync = pin_sync_reg[2];
  assign sync_held = ~pin_sync_reg[3];

  // one selects the first input, zero the second
  assign sel_clk = glob_select ? pin_sync_reg[0] : pin_sync_reg[1];
  assign src_tick = sel_clk & ~sel_clk_prev_reg;

  // shutdown overrides the gate pin and the global enable
  assign outputs_allowed = glob_enable & gate_sync & ~glob_shutdown;

  // two-flop synchronisers for all asynchronous pins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_meta_reg <= 4'h0;
      pin_sync_reg <= 4'h0;
    end else begin
      pin_meta_reg <= {sync_n_i, output_gate_pin_i,
                       second_clock_input_i, first_clock_input_i};
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // source clock edge detect and bypass copy
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sel_clk_prev_reg <= 1'b0;
      bypass_clk_reg <= 1'b0;
    end else begin
      sel_clk_prev_reg <= sel_clk;
      bypass_clk_reg <= sel_clk & ~glob_shutdown;
    end
  end

  // bus handshake: answer one cycle after the request; no request is taken in the ack cycle
  always_comb begin
    wb_state_next = wb_state_reg;
    unique case (wb_state_reg)
      WB_IDLE: begin
        if (wb_req_i.cyc && wb_req_i.stb) begin
          wb_state_next = WB_ACK;
        end
      end
      WB_ACK: wb_state_next = WB_IDLE;
      default: wb_state_next = WB_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_state_reg <= WB_IDLE;
      ack_reg <= 1'b0;
      rdat_reg <= 32'h0000_0000;
    end else begin
      wb_state_reg <= wb_state_next;
      ack_reg <= wb_take;
      rdat_reg <= (wb_take && !wb_req_i.we) ? rd_word : 32'h0000_0000;
    end
  end

  // read selection; unmapped words answer with zero
  assign rd_word = !wb_hit ? 32'h0000_0000 :
                   (wb_idx < 4'(NUM_CHAN)) ? 32'(chan_reg[wb_idx[2:0]]) :
                   (wb_idx == IDX_BOOST) ? boost_reg :
                   (wb_idx == IDX_GLOBAL) ? global_reg :
                   {14'h0000, sync_held, glob_shutdown,
                    active_reg, out_reg};

  assign wb_rsp_o.ack = ack_reg;
  assign wb_rsp_o.dat = rdat_reg;

  // channel control words; the soft reset bit itself is never stored
  always_ff @(posedge clk_i) begin
    if (rst_i || soft_reset) begin
      for (int i = 0; i < NUM_CHAN; i++) begin
        chan_reg[i] <= cod_chan_s'(CHAN_RESET);
      end
    end else if (wb_write && (wb_idx < 4'(NUM_CHAN))) begin
      // each write reaches only the addressed channel
      chan_reg[wb_idx[2:0]] <= cod_chan_s'(merge_sel(
        32'(chan_reg[wb_idx[2:0]]), wb_req_i.dat, wb_req_i.sel,
        CHAN_MASK));
    end
  end

  // global and boost words; a soft reset write drops its other fields
  always_ff @(posedge clk_i) begin
    if (rst_i || soft_reset) begin
      global_reg <= GLOBAL_RESET;
      boost_reg <= BOOST_RESET;
    end else if (wb_write && (wb_idx == IDX_GLOBAL)) begin
      // enable resets to one, but outputs still need their channel enable bit written
      global_reg <= merge_sel(global_reg, wb_req_i.dat, wb_req_i.sel,
                              GLOBAL_MASK);
    end else if (wb_write && (wb_idx == IDX_BOOST)) begin
      boost_reg <= merge_sel(boost_reg, wb_req_i.dat, wb_req_i.sel,
                             BOOST_MASK);
    end
  end

  // per-channel output path
  generate
    for (genvar c = 0; c < NUM_CHAN; c++) begin : g_chan
      cod_mode_e mode;
      logic has_div;
      logic has_dly;
      logic enable_ok;
      logic div_hold;
      logic path_clk;
      logic [11:0] step_ps;

      // path stages follow the mode field
      assign mode = chan_reg[c].path_mode_select;
      assign has_div = mode_has_div(mode);
      assign has_dly = mode_has_dly(mode);

      // channel bit counts only with global enable and gate pin
      assign enable_ok = chan_reg[c].channel_output_enable & outputs_allowed;

      // dividers stay cleared while unused, shut down or sync is low,
      // so releasing sync starts every divider on the same edge
      assign div_hold = ~has_div | glob_shutdown | sync_held;

      // the divide field only matters in divided modes
      assign path_clk = has_div ? div_clk[c] : bypass_clk_reg;

      // delay steps count only when the delay stage is in
      assign step_ps = has_dly ?
        12'(12'(chan_reg[c].delay_step_field) * DLY_STEP_PS) : 12'h000;

      cod_channel_divider u_div (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .hold_i(div_hold),
        .tick_i(src_tick),
        .half_ratio_i(chan_reg[c].divide_field),
        .div_clk_o(div_clk[c])
      );

      // registered output, enable flag and reported path latency
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          out_reg[c] <= 1'b0;
          active_reg[c] <= 1'b0;
          dly_ps_reg[c] <= 12'h000;
        end else begin
          out_reg[c] <= enable_ok & path_clk;
          active_reg[c] <= enable_ok;
          dly_ps_reg[c] <= 12'(mode_latency(mode) + step_ps);
        end
      end
    end
  endgenerate

  // outputs; sub-cycle latency cannot be shown on a 10 ns clock,
  // so it is reported as a figure in ps per channel instead
  assign clock_output_n_o = out_reg;
  assign channel_active_o = active_reg;
  assign path_delay_ps_o = dly_ps_reg;
  // boost is applied to every output at once
  assign boost_enable_o = boost_reg[BOOST_BIT];
  assign device_shutdown_o = glob_shutdown;
  assign input_source_select_o = glob_select;

endmodule

`default_nettype wire

// file: rtl/cod_pkg.sv
// package for the eight-channel clock output control block
// assumes a classic wishbone master on the register port, one 100 MHz clock
//
// Overview of operation
// - eight identical control words, one per output
// - soft reset bit restores defaults, self-clears
// - soft reset write ignores other channel-0 fields
// - path mode bits 18:17 select output stages
// - modes add 100, 400, 500 ps latency
// - divider acts only in divided modes
// - divide bits 15:8, ratio twice field
// - delay bits 7:4 add 150 ps steps
// - channel enable needs global enable and pin
// - global enable bit 27, resets to one
// - power-down bit 26 overrides all channel outputs
// - input select bit 28, zero picks second
// - channels reset bypassed, disabled, zero delay
package cod_pkg;

  localparam int NUM_CHAN = 8;

  // register indices; byte address is four times the index
  localparam logic [3:0] IDX_CHAN0 = 4'h0;
  localparam logic [3:0] IDX_BOOST = 4'h9;
  localparam logic [3:0] IDX_GLOBAL = 4'hE;
  localparam logic [3:0] IDX_STATUS = 4'hF;

  // channel word field positions
  localparam int SOFT_RST_BIT = 31;
  localparam int MODE_LSB = 17;
  localparam int EN_BIT = 16;
  localparam int DIV_LSB = 8;
  localparam int DLY_LSB = 4;

  // global word and boost word bit positions
  localparam int SEL_BIT = 28;
  localparam int GLOB_EN_BIT = 27;
  localparam int PD_BIT = 26;
  localparam int BOOST_BIT = 16;

  // writable bits of each word; all others read as zero
  localparam logic [31:0] CHAN_MASK = 32'h0007_FFF0;
  localparam logic [31:0] GLOBAL_MASK = 32'h1C00_0000;
  localparam logic [31:0] BOOST_MASK = 32'h0001_0000;

  // reset values
  localparam logic [31:0] CHAN_RESET = 32'h0000_0100;
  localparam logic [31:0] GLOBAL_RESET = 32'h0800_0000;
  localparam logic [31:0] BOOST_RESET = 32'h0000_0000;

  // added path latency in ps relative to bypass, and delay step in ps
  localparam logic [11:0] LAT_DIV_PS = 12'h064;
  localparam logic [11:0] LAT_DLY_PS = 12'h190;
  localparam logic [11:0] LAT_DIVDLY_PS = 12'h1F4;
  localparam logic [11:0] DLY_STEP_PS = 12'h096;

  // path mode field encoding
  typedef enum logic [1:0] {
    MODE_BYPASS = 2'h0,
    MODE_DIV = 2'h1,
    MODE_DLY = 2'h2,
    MODE_DIVDLY = 2'h3
  } cod_mode_e;

  // one channel control word
  typedef struct packed {
    logic soft_reset;
    logic [11:0] rsv_hi;
    cod_mode_e path_mode_select;
    logic channel_output_enable;
    logic [7:0] divide_field;
    logic [3:0] delay_step_field;
    logic [3:0] rsv_lo;
  } cod_chan_s;

  // wishbone classic request and answer
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [5:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } cod_wb_req_s;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } cod_wb_rsp_s;

endpackage

// file: rtl/cod_channel_divider.sv
// even-ratio divider for one output channel
// assumes tick_i is a one-cycle pulse per rising edge of the source clock
`timescale 1ns/10ps
`default_nettype none

module cod_channel_divider (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic hold_i,
  input wire logic tick_i,
  input wire logic [7:0] half_ratio_i,
  output logic div_clk_o
);

  logic [7:0] cnt_reg;
  logic [7:0] last_cnt;
  logic stop;

  // a zero field is invalid, so the divider simply parks low
  assign stop = hold_i | (half_ratio_i == 8'h00);
  assign last_cnt = 8'(half_ratio_i - 8'h01);

  // toggle once every half_ratio source cycles
  always_ff @(posedge clk_i) begin
    if (rst_i || stop) begin
      cnt_reg <= 8'h00;
      div_clk_o <= 1'b0;
    end else if (tick_i) begin
      if (cnt_reg == last_cnt) begin
        cnt_reg <= 8'h00;
        div_clk_o <= ~div_clk_o;
      end else begin
        cnt_reg <= 8'(cnt_reg + 8'h01);
      end
    end
  end

endmodule

`default_nettype wire

// file: sim/cod_clock_sink.sv
// far-side model: receivers that count rising edges of each clock output
// assumes clk_i samples the outputs well above their rate
`timescale 1ns/10ps
`default_nettype none
module cod_clock_sink (
  input wire logic clk_i,
  input wire logic clr_i,
  input wire logic [7:0] clk_in_i,
  output logic [7:0][15:0] edges_o
);
  logic [7:0] last_reg;
  // edge count per output; clr_i restarts a window
  always_ff @(posedge clk_i) begin
    last_reg <= clk_in_i;
    for (int i = 0; i < 8; i++) begin
      if (clr_i) begin
        edges_o[i] <= 16'h0000;
      end else if (clk_in_i[i] && !last_reg[i]) begin
        edges_o[i] <= edges_o[i] + 16'h0001;
      end
    end
  end
endmodule
`default_nettype wire

// file: sim/cod_clock_control_assertions.sv
// port checker for the clock output control block
// assumes it is bound to the top module and sees only its ports
`timescale 1ns/10ps
`default_nettype none
module cod_clock_control_assertions (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire cod_pkg::cod_wb_req_s wb_req_i,
  input wire cod_pkg::cod_wb_rsp_s wb_rsp_o,
  input wire logic output_gate_pin_i,
  input wire logic [cod_pkg::NUM_CHAN-1:0] clock_output_n_o,
  input wire logic [cod_pkg::NUM_CHAN-1:0] channel_active_o,
  input wire logic [cod_pkg::NUM_CHAN-1:0][11:0] path_delay_ps_o,
  input wire logic device_shutdown_o,
  input wire logic input_source_select_o
);
  import cod_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // a request is taken only outside the ack cycle
  wire logic taken = wb_req_i.cyc && wb_req_i.stb && !wb_rsp_o.ack;
  wire logic gwr = taken && wb_req_i.we && wb_req_i.adr == 6'h38
    && wb_req_i.sel[3];
  a_ack_follows: assert property (taken |=> wb_rsp_o.ack)
    else $error("no ack after request");
  a_ack_single: assert property (wb_rsp_o.ack |=> !wb_rsp_o.ack)
    else $error("ack longer than one cycle");
  a_dat_idle: assert property (!wb_rsp_o.ack |-> wb_rsp_o.dat == '0)
    else $error("read data outside ack");
  a_sel_write: assert property (gwr |=> ##1
    input_source_select_o == $past(wb_req_i.dat[28], 2))
    else $error("input select not from global word");
  a_pd_write: assert property (gwr |=> ##1
    device_shutdown_o == $past(wb_req_i.dat[26], 2))
    else $error("power-down not from global word");
  a_pd_quiet: assert property (device_shutdown_o [*3] |->
    clock_output_n_o == '0 && channel_active_o == '0)
    else $error("output alive in power-down");
  a_gate_quiet: assert property (!output_gate_pin_i [*4] |->
    channel_active_o == '0)
    else $error("channel active with gate pin low");
  a_idle_low: assert property (channel_active_o == '0 [*3] |->
    clock_output_n_o == '0)
    else $error("clock on inactive outputs");
  a_delay_cap: assert property (path_delay_ps_o[0] <= 12'hABE)
    else $error("delay above maximum");
  c_gwr: cover property (gwr);
  c_pd: cover property (device_shutdown_o);
  c_read: cover property (taken && !wb_req_i.we);
endmodule
bind cod_clock_control cod_clock_control_assertions chk (
  .clk_i(clk_i),
  .rst_i(rst_i),
  .wb_req_i(wb_req_i),
  .wb_rsp_o(wb_rsp_o),
  .output_gate_pin_i(output_gate_pin_i),
  .clock_output_n_o(clock_output_n_o),
  .channel_active_o(channel_active_o),
  .path_delay_ps_o(path_delay_ps_o),
  .device_shutdown_o(device_shutdown_o),
  .input_source_select_o(input_source_select_o)
);
`default_nettype wire

// file: sim/cod_clock_control_test.sv
// self-checking bench for the clock output control block
// assumes wishbone ack one cycle after a taken request
`timescale 1ns/10ps
`default_nettype none
module cod_clock_control_test;
  import cod_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  cod_wb_req_s req = '0;
  cod_wb_rsp_s rsp;
  logic gate = 1'b1;
  logic sync_n = 1'b1;
  logic clr = 1'b0;
  logic [3:0] src = 4'h0;
  logic [7:0] outs;
  logic [7:0] act;
  logic [7:0][11:0] dly;
  logic [7:0][15:0] edges;
  logic boost;
  logic [31:0] q;
  logic [31:0] w;
  logic [31:0] mdl [8];
  int fail_count = 0;
  int total_checks = 0;
  int ch;
  int d;
  int n;
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  // source clocks: first has period 8 cycles, second 16
  always @(posedge clk_i) src <= src + 4'h1;
  cod_clock_control dut (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req),
    .wb_rsp_o(rsp), .first_clock_input_i(src[2]),
    .second_clock_input_i(src[3]), .output_gate_pin_i(gate),
    .sync_n_i(sync_n), .clock_output_n_o(outs), .channel_active_o(act),
    .path_delay_ps_o(dly), .boost_enable_o(boost), .device_shutdown_o(),
    .input_source_select_o());
  cod_clock_sink sink (.clk_i(clk_i), .clr_i(clr), .clk_in_i(outs),
    .edges_o(edges));
  task automatic print_verdict;
    if (fail_count == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
      fail_count++;
    end
  endtask
  // one classic cycle; holds the request until ack is sampled
  task automatic bus(logic we, logic [5:0] a, logic [31:0] dt);
    int k;
    req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hF, dat: dt};
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (rsp.ack !== 1'b1 && k < 50);
    q = rsp.dat;
    if (k >= 50) begin
      fail_count++;
      print_verdict();
    end
    req <= '0;
    @(posedge clk_i);
  endtask
  function automatic logic [31:0] cw(logic [1:0] m, logic [7:0] dv,
    logic [3:0] st);
    return {13'h0000, m, 1'b1, dv, st, 4'h0};
  endfunction
  function automatic logic [31:0] exp_dly(logic [1:0] m, logic [3:0] st);
    logic [11:0] s;
    s = 12'(st) * DLY_STEP_PS;
    case (m)
      2'h0: return 32'h0000_0000;
      2'h1: return 32'(LAT_DIV_PS);
      2'h2: return 32'(LAT_DLY_PS + s);
      default: return 32'(LAT_DIVDLY_PS + s);
    endcase
  endfunction
  // count rising edges over 256 cycles, allowing one edge of slack
  task automatic edges_near(int c, int e);
    logic [15:0] v;
    repeat (40) @(posedge clk_i);
    clr <= 1'b1;
    @(posedge clk_i);
    clr <= 1'b0;
    repeat (256) @(posedge clk_i);
    v = edges[c];
    // kept four-state so an unknown count cannot slip through as a pass
    check("edges", 32'((v + 1 >= e) && (v <= e + 1)), 32'h0000_0001);
  endtask
  initial begin
    void'($urandom(32110));
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    for (int i = 0; i < 8; i++) begin
      bus(1'b0, 6'(4 * i), '0);
      check("chan reset", q, CHAN_RESET);
      mdl[i] = CHAN_RESET;
    end
    bus(1'b0, 6'h38, '0);
    check("global reset", q, GLOBAL_RESET);
    bus(1'b0, 6'h28, '0);
    check("unmapped", q, 32'h0000_0000);
    // random words read back from their own channel and leave the next channel unchanged
    for (int k = 0; k < 16; k++) begin
      ch = $urandom % 8;
      w = $urandom;
      w[31] = 1'b0;
      mdl[ch] = w & CHAN_MASK;
      bus(1'b1, 6'(4 * ch), w);
      bus(1'b0, 6'(4 * ch), '0);
      check("chan rw", q, mdl[ch]);
      bus(1'b0, 6'(4 * ((ch + 1) % 8)), '0);
      check("chan other", q, mdl[(ch + 1) % 8]);
    end
    bus(1'b1, 6'h38, 32'h1800_0000);
    for (int m = 0; m < 4; m++) begin
      n = $urandom % 16;
      bus(1'b1, 6'h04, cw(2'(m), 8'h03, 4'(n)));
      repeat (4) @(posedge clk_i);
      check("delay", 32'(dly[1]), exp_dly(2'(m), 4'(n)));
    end
    d = 1 << ($urandom % 3);
    bus(1'b1, 6'h08, cw(2'h1, 8'(d), 4'h0));
    sync_n <= 1'b0;
    repeat (3) @(posedge clk_i);
    sync_n <= 1'b1;
    edges_near(2, 16 / d);
    bus(1'b1, 6'h08, cw(2'h0, 8'h03, 4'h0));
    edges_near(2, 32);
    bus(1'b1, 6'h38, 32'h0800_0000);
    edges_near(2, 16);
    gate <= 1'b0;
    repeat (6) @(posedge clk_i);
    check("gate low", 32'(act), 32'h0000_0000);
    gate <= 1'b1;
    repeat (6) @(posedge clk_i);
    check("gate high", 32'(act[2]), 32'h0000_0001);
    bus(1'b1, 6'h38, 32'h0000_0000);
    repeat (4) @(posedge clk_i);
    check("global off", 32'(act), 32'h0000_0000);
    bus(1'b1, 6'h38, 32'h0C00_0000);
    edges_near(2, 0);
    check("pd active", 32'(act), 32'h0000_0000);
    check("pd outs", 32'(outs), 32'h0000_0000);
    bus(1'b0, 6'h3C, '0);
    check("status pd", q, 32'h0001_0000);
    // boost word is only written when boost is wanted
    bus(1'b1, 6'h24, 32'h0001_0000);
    check("boost on", 32'(boost), 32'h0000_0001);
    bus(1'b1, 6'h00, 32'h8007_FFF0);
    bus(1'b0, 6'h00, '0);
    check("soft ch0", q, CHAN_RESET);
    bus(1'b0, 6'h08, '0);
    check("soft ch2", q, CHAN_RESET);
    bus(1'b0, 6'h38, '0);
    check("soft global", q, GLOBAL_RESET);
    check("soft boost", 32'(boost), 32'h0000_0000);
    print_verdict();
  end
endmodule
`default_nettype wire
